// *** pkg/sar_cell_pkg.sv ***
/*
  constants for the cell datapath: cell geometry, buffer depths, crc, timing.
  assumes a 20 MHz core clock and an 8-bit phy cell interface.
*/
package sar_cell_pkg;
  localparam int unsigned CELL_BYTES      = 53;
  localparam int unsigned HDR_BYTES       = 4;
  localparam int unsigned PAYLOAD_BYTES   = 48;
  localparam int unsigned CELL_WORDS      = 13;
  localparam int unsigned PAYLOAD_WORDS   = 12;
  localparam int unsigned TX_CELLS        = 8;
  localparam int unsigned RX_CELLS        = 32;
  localparam int unsigned MAX_VC          = 1023;
  localparam int unsigned GROUPS          = 4;
  localparam int unsigned FULL_LEAD_CYC   = 4;
  localparam int unsigned RATE_STEP_KBPS  = 32;
  localparam int unsigned PEAK_MBPS       = 155;
  localparam int unsigned CLK_NS          = 50;
  localparam int unsigned GUARD_NS        = 200;
  localparam int unsigned GUARD_CYC       = (GUARD_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [31:0] CRC_POLY        = 32'h04c11db7;
  localparam logic [31:0] CRC_INIT        = 32'hffffffff;
  localparam logic [31:0] CRC_RESIDUE     = 32'hc704dd7b;
  localparam logic [31:0] IDLE_HDR        = 32'h00000001;
  localparam logic [7:0]  IDLE_FILL       = 8'h6a;
  localparam logic [15:0] RATE_RESET      = 16'h0000;
  typedef enum logic [1:0] {AAL_5, AAL_34, AAL_NULL} aal_mode_t;
endpackage

// *** design/sync_fifo.sv ***
/*
  word fifo with valid/ready on both sides and registered read data.
  assumes a single clock; depth is a power of two.
*/
`timescale 1ns/1ns
module sync_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk_in,
  input  wire logic             arst_n_in,
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  input  wire logic [WIDTH-1:0] wr_data_in,
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in,
  output logic      [WIDTH-1:0] rd_data_out
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wp_q, wp_d, rp_q, rp_d;
  logic [WIDTH-1:0] rd_q, rd_d;
  logic             rv_q, rv_d;
  logic             push, pop, stored;

  // storage count excludes the word held in the output register
  always_comb begin
    stored = (wp_q != rp_q);
    push   = wr_valid_in && wr_ready_out;
    pop    = stored && (!rv_q || rd_ready_in);
    wp_d   = push ? wp_q + 1'b1 : wp_q;
    rp_d   = pop ? rp_q + 1'b1 : rp_q;
    rv_d   = pop ? 1'b1 : (rd_ready_in ? 1'b0 : rv_q);
    rd_d   = pop ? mem_q[rp_q[AW-1:0]] : rd_q;
  end

  assign wr_ready_out = (wp_q[AW-1:0] != rp_q[AW-1:0]) || (wp_q[AW] == rp_q[AW]);
  assign rd_valid_out = rv_q;
  assign rd_data_out  = rd_q;

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_q[wp_q[AW-1:0]] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wp_q <= '0;
      rp_q <= '0;
      rv_q <= 1'b0;
      rd_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      rv_q <= rv_d;
      rd_q <= rd_d;
    end
  end
endmodule // sync_fifo

// *** design/atm_sar_cell_datapath.sv ***
/*
  transmit and receive cell datapath of an atm segmentation/reassembly core.
  assumes payload words arrive from a host buffer, phy pins are asynchronous
  and are sampled through two flops, tx full through three, and the link clock is slower than clk_in.
*/
// Functional notes
// - transmit buffer holds eight cells of sixteen words each, 128 words.
// - idle cells enter the transmit buffer like data cells.
// - transmit stage unpacks words to bytes on the core clock.
// - receive stage packs bytes to words and drops idle cells.
// - receive cells cross into core domain; buffer holds thirty-two cells.
// - a four-byte header is prepended to every transmitted cell.
// - aal5 crc computed over outgoing packet and appended at end.
// - receive side checks aal5 crc and acts on end-of-packet.
// - receive header removed and used to select the dma entry.
// - only 48-byte payloads cross host side, requested in 48-byte units.
// - phy link is 8 bits per direction carrying 53-byte cells.
// - core runs on the host clock with 32-bit internal words.
// - one host burst carries at most twelve words.
// - up to 1023 virtual circuits, normally on path zero.
// - scheduler reads a group rate table to pick the next circuit.
// - circuits in one group served fifo, whole packet at a time.
// - group peak rate up to 155 Mbit/s in fine steps.
// - aal3/4 moves 48-byte payloads and detects end of message.
// - null mode passes payloads without aal processing.
// - a 32-bit host data buffer feeds tx and drains rx.
// - start-of-cell flag driven with the first transmitted byte.
// - full stops transmit enable until it is removed.
`timescale 1ns/1ns
module atm_sar_cell_datapath
  import sar_cell_pkg::*;
#(
  parameter int unsigned VC_W = 10
) (
  input  wire logic            clk_in,
  input  wire logic            arst_n_in,
  input  wire logic [31:0]     host_wdata_in,
  input  wire logic            host_wvalid_in,
  input  wire logic            host_wlast_in,
  input  wire logic [VC_W-1:0] host_vc_in,
  input  wire logic [1:0]      host_group_in,
  input  wire logic [1:0]      aal_mode_in,
  input  wire logic [15:0]     group_rate_in,
  input  wire logic [1:0]      group_sel_in,
  input  wire logic            group_load_in,
  output logic                 host_wready_out,
  output logic                 host_burst_req_out,
  output logic [31:0]          host_rdata_out,
  output logic                 host_rvalid_out,
  output logic                 host_rlast_out,
  output logic                 host_rcrc_ok_out,
  output logic                 host_reom_out,
  output logic [VC_W-1:0]      host_rdma_out,
  output logic [7:0]           tx_data_out,
  output logic                 tx_start_of_cell_out,
  output logic                 tx_byte_enable_out,
  input  wire logic            tx_full_in,
  input  wire logic            rx_link_clk_in,
  input  wire logic [7:0]      rx_data_in,
  input  wire logic            rx_start_of_cell_in,
  input  wire logic            rx_empty_n_in
);
  // crc step over one byte, msb first, reflected polynomial not used
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = (r[31] ^ b[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction
  function automatic logic [31:0] crc_word(input logic [31:0] c, input logic [31:0] w);
    return crc_byte(crc_byte(crc_byte(crc_byte(c, w[31:24]), w[23:16]), w[15:8]), w[7:0]);
  endfunction

  // rate table, one credit counter per group
  logic [15:0] rate_q [GROUPS];
  logic [15:0] rate_d [GROUPS];
  logic [15:0] cred_q [GROUPS];
  logic [15:0] cred_d [GROUPS];
  logic [GROUPS-1:0] due;
  genvar g;
  generate
    for (g = 0; g < GROUPS; g++) begin : g_rate
      assign due[g] = (cred_q[g] == 16'h0000) && (rate_q[g] != 16'h0000);
    end
  endgenerate

  typedef enum logic [2:0] {T_PICK, T_HDR, T_PAY, T_CRC, T_IDLE} tx_st_t;
  tx_st_t       ts_q, ts_d;
  logic [3:0]   tw_q, tw_d;
  logic [31:0]  tcrc_q, tcrc_d;
  logic [1:0]   tg_q, tg_d;
  logic         fin_q, fin_d;
  logic         burst_q, burst_d;
  logic [31:0]  fw_data;
  logic         fw_valid, fw_ready;
  logic         f_rvalid, f_rready;
  logic [31:0]  f_rdata;

  // scheduler and cell former; payload words come straight off the host buffer
  always_comb begin
    ts_d = ts_q;
    tw_d = tw_q;
    tcrc_d = tcrc_q;
    tg_d = tg_q;
    fin_d = fin_q;
    fw_valid = 1'b0;
    fw_data = 32'h00000000;
    host_wready_out = 1'b0;
    for (int k = 0; k < GROUPS; k++) begin
      rate_d[k] = (group_load_in && group_sel_in == k[1:0]) ? group_rate_in : rate_q[k];
      cred_d[k] = (cred_q[k] != 16'h0000) ? cred_q[k] - 16'h0001 : cred_q[k];
    end
    case (ts_q)
      T_PICK: begin
        // pending packet wins when its group is due or it continues an unfinished packet (fin_q)
        if (host_wvalid_in && (due[host_group_in] || fin_q)) begin
          tg_d = host_group_in;
          ts_d = T_HDR;
          cred_d[host_group_in] = rate_q[host_group_in];
        end else begin
          ts_d = T_IDLE;
        end
        tw_d = 4'h0;
      end
      T_HDR: begin
        fw_valid = 1'b1;
        fw_data = {4'h0, 8'h00, 6'h00, host_vc_in, 4'h0};
        if (fw_ready) ts_d = T_PAY;
      end
      T_PAY: begin
        // last word of a packet gives way to the crc in aal5
        fw_valid = host_wvalid_in && !(host_wlast_in && aal_mode_in == AAL_5 &&
                   tw_q == 4'(PAYLOAD_WORDS - 1));
        fw_data = host_wdata_in;
        host_wready_out = fw_valid && fw_ready;
        if (host_wready_out) begin
          tcrc_d = (aal_mode_in == AAL_5) ? crc_word(tcrc_q, host_wdata_in) : tcrc_q;
          tw_d = tw_q + 4'h1;
          fin_d = !host_wlast_in;
          if (tw_q == 4'(PAYLOAD_WORDS - 1)) ts_d = T_PICK;
        end
        if (host_wvalid_in && host_wlast_in && aal_mode_in == AAL_5 &&
            tw_q == 4'(PAYLOAD_WORDS - 1)) ts_d = T_CRC;
      end
      T_CRC: begin
        fw_valid = 1'b1;
        fw_data = ~tcrc_q;
        if (fw_ready) begin
          host_wready_out = 1'b1;
          tcrc_d = CRC_INIT;
          fin_d = 1'b0;
          ts_d = T_PICK;
        end
      end
      T_IDLE: begin
        // idle cells go through the same buffer as data
        fw_valid = 1'b1;
        fw_data = (tw_q == 4'h0) ? IDLE_HDR : {4{IDLE_FILL}};
        if (fw_ready) begin
          tw_d = tw_q + 4'h1;
          if (tw_q == 4'(CELL_WORDS - 1)) ts_d = T_PICK;
        end
      end
      default: ts_d = T_PICK;
    endcase
    // registered so the request leaves straight from a flop
    burst_d = (ts_d == T_PAY) && (tw_d == 4'h0);
  end

  sync_fifo #(.WIDTH(32), .DEPTH(TX_CELLS * 16)) u_tx_cell_buffer (
    .clk_in       (clk_in),
    .arst_n_in    (arst_n_in),
    .wr_valid_in  (fw_valid),
    .wr_ready_out (fw_ready),
    .wr_data_in   (fw_data),
    .rd_valid_out (f_rvalid),
    .rd_ready_in  (f_rready),
    .rd_data_out  (f_rdata)
  );

  // tx phy stage: word to byte, header word then 48 payload bytes
  logic [31:0] sh_q, sh_d;
  logic [1:0]  bi_q, bi_d;
  logic [5:0]  bc_q, bc_d;
  logic        bv_q, bv_d;
  logic [1:0]  full_s1_q, full_s2_q;
  logic [7:0]  txd_q, txd_d;
  logic        tx_start_of_cell_q, tx_start_of_cell_d, ten_q, ten_d;
  always_comb begin
    sh_d = sh_q;
    bi_d = bi_q;
    bc_d = bc_q;
    bv_d = bv_q;
    txd_d = txd_q;
    tx_start_of_cell_d = 1'b0;
    ten_d = 1'b0;
    f_rready = !bv_q;
    if (!bv_q && f_rvalid) begin
      sh_d = f_rdata;
      bv_d = 1'b1;
      bi_d = 2'd0;
    end else if (bv_q && !full_s2_q[0]) begin
      ten_d = 1'b1;
      tx_start_of_cell_d = (bc_q == 6'd0);
      bc_d = (bc_q == 6'(CELL_BYTES - 1)) ? 6'd0 : bc_q + 6'd1;
      if (bc_q == 6'(HDR_BYTES)) begin
        // hec slot after the header word; the framer owns the real check byte
        txd_d = 8'h00;
      end else begin
        txd_d = sh_q[31:24];
        sh_d = {sh_q[23:0], 8'h00};
        bi_d = bi_q + 2'd1;
        if (bi_q == 2'd3) bv_d = 1'b0;
      end
    end
  end

  // rx link clock domain is sampled: two flops then edge detect
  logic [2:0]  rclk_q;
  logic [7:0]  rd_s1_q, rd_s2_q;
  logic        rx_start_of_cell_s1_q, rx_start_of_cell_s2_q, remp_s1_q, remp_s2_q;
  logic        redge;
  assign redge = rclk_q[1] && !rclk_q[2];

  // rx phy stage: bytes to words, idle cells filtered
  logic [31:0] pk_q, pk_d;
  logic [5:0]  rb_q, rb_d;
  logic        ridle_q, ridle_d;
  logic        rw_valid, rw_ready;
  logic [33:0] rw_data;
  always_comb begin
    pk_d = pk_q;
    rb_d = rb_q;
    ridle_d = ridle_q;
    rw_valid = 1'b0;
    rw_data = {2'b00, pk_q};
    if (redge && !remp_s2_q) begin
      pk_d = {pk_q[23:0], rd_s2_q};
      if (rx_start_of_cell_s2_q) rb_d = 6'd1;
      else rb_d = (rb_q == 6'(CELL_BYTES)) ? 6'd0 : rb_q + 6'd1;
      // hec byte is shifted through but never closes a word
      if (rb_d == 6'(HDR_BYTES) || (rb_d[1:0] == 2'b01 && rb_d > 6'(HDR_BYTES + 1))) begin
        ridle_d = (rb_d == 6'd4) ? ({pk_q[23:0], rd_s2_q} == IDLE_HDR) : ridle_q;
        rw_valid = !ridle_d;
        rw_data = {(rb_d == 6'(HDR_BYTES)), (rb_d == 6'(CELL_BYTES)), pk_q[23:0], rd_s2_q};
      end
    end
  end

  logic        rf_valid, rf_ready;
  logic [33:0] rf_data;
  sync_fifo #(.WIDTH(34), .DEPTH(RX_CELLS * 16)) u_rx_cell_buffer (
    .clk_in       (clk_in),
    .arst_n_in    (arst_n_in),
    .wr_valid_in  (rw_valid),
    .wr_ready_out (rw_ready),
    .wr_data_in   (rw_data),
    .rd_valid_out (rf_valid),
    .rd_ready_in  (rf_ready),
    .rd_data_out  (rf_data)
  );

  // rx header/adaptation stage: header stripped, crc checked over payload
  logic [31:0] rcrc_q, rcrc_d, hd_q, hd_d;
  logic        hv_q, hv_d, hl_q, hl_d, ok_q, ok_d, eom_q, eom_d;
  logic [VC_W-1:0] dma_q, dma_d;
  logic        pti_eop_q, pti_eop_d;
  always_comb begin
    rcrc_d = rcrc_q;
    dma_d = dma_q;
    pti_eop_d = pti_eop_q;
    hd_d = hd_q;
    hv_d = 1'b0;
    hl_d = 1'b0;
    ok_d = ok_q;
    eom_d = 1'b0;
    rf_ready = 1'b1;
    if (rf_valid) begin
      if (rf_data[33]) begin
        dma_d = rf_data[VC_W+3:4];
        pti_eop_d = rf_data[1];
      end else begin
        hd_d = rf_data[31:0];
        hv_d = 1'b1;
        hl_d = rf_data[32] && (pti_eop_q || aal_mode_in == AAL_NULL);
        eom_d = rf_data[32] && aal_mode_in == AAL_34 && pti_eop_q;
        rcrc_d = crc_word(rcrc_q, rf_data[31:0]);
        if (hl_d) begin
          ok_d = (aal_mode_in != AAL_5) || (rcrc_d == CRC_RESIDUE);
          rcrc_d = CRC_INIT;
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ts_q <= T_PICK;
      tw_q <= 4'h0;
      tcrc_q <= CRC_INIT;
      tg_q <= 2'd0;
      fin_q <= 1'b0;
      burst_q <= 1'b0;
      for (int k = 0; k < GROUPS; k++) begin
        rate_q[k] <= RATE_RESET;
        cred_q[k] <= RATE_RESET;
      end
      sh_q <= 32'h00000000;
      bi_q <= 2'd0;
      bc_q <= 6'd0;
      bv_q <= 1'b0;
      full_s1_q <= 2'b00;
      full_s2_q <= 2'b11;
      txd_q <= 8'h00;
      tx_start_of_cell_q <= 1'b0;
      ten_q <= 1'b0;
      rclk_q <= 3'b000;
      rd_s1_q <= 8'h00;
      rd_s2_q <= 8'h00;
      rx_start_of_cell_s1_q <= 1'b0;
      rx_start_of_cell_s2_q <= 1'b0;
      remp_s1_q <= 1'b1;
      remp_s2_q <= 1'b1;
      pk_q <= 32'h00000000;
      rb_q <= 6'd0;
      ridle_q <= 1'b0;
      rcrc_q <= CRC_INIT;
      dma_q <= '0;
      pti_eop_q <= 1'b0;
      hd_q <= 32'h00000000;
      hv_q <= 1'b0;
      hl_q <= 1'b0;
      ok_q <= 1'b0;
      eom_q <= 1'b0;
    end else begin
      ts_q <= ts_d;
      tw_q <= tw_d;
      tcrc_q <= tcrc_d;
      tg_q <= tg_d;
      fin_q <= fin_d;
      burst_q <= burst_d;
      rate_q <= rate_d;
      cred_q <= cred_d;
      sh_q <= sh_d;
      bi_q <= bi_d;
      bc_q <= bc_d;
      bv_q <= bv_d;
      full_s1_q <= {full_s1_q[0], tx_full_in};
      full_s2_q <= {full_s2_q[0], full_s1_q[1]};
      txd_q <= txd_d;
      tx_start_of_cell_q <= tx_start_of_cell_d;
      ten_q <= ten_d;
      rclk_q <= {rclk_q[1:0], rx_link_clk_in};
      rd_s1_q <= rx_data_in;
      rd_s2_q <= rd_s1_q;
      rx_start_of_cell_s1_q <= rx_start_of_cell_in;
      rx_start_of_cell_s2_q <= rx_start_of_cell_s1_q;
      remp_s1_q <= rx_empty_n_in;
      remp_s2_q <= remp_s1_q;
      pk_q <= pk_d;
      rb_q <= rb_d;
      ridle_q <= ridle_d;
      rcrc_q <= rcrc_d;
      dma_q <= dma_d;
      pti_eop_q <= pti_eop_d;
      hd_q <= hd_d;
      hv_q <= hv_d;
      hl_q <= hl_d;
      ok_q <= ok_d;
      eom_q <= eom_d;
    end
  end

  assign host_burst_req_out   = burst_q;
  assign tx_data_out          = txd_q;
  assign tx_start_of_cell_out = tx_start_of_cell_q;
  assign tx_byte_enable_out   = ten_q;
  assign host_rdata_out       = hd_q;
  assign host_rvalid_out      = hv_q;
  assign host_rlast_out       = hl_q;
  assign host_rcrc_ok_out     = ok_q;
  assign host_reom_out        = eom_q;
  assign host_rdma_out        = dma_q;

  a_full_stops_tx: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    full_s2_q[0] |=> !tx_byte_enable_out) else $error("byte sent while full");
  a_soc_with_en: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    tx_start_of_cell_out |-> tx_byte_enable_out) else $error("soc without enable");
  a_idle_fill: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (ts_q == T_PICK && !host_wvalid_in) |=> ts_q == T_IDLE) else $error("no idle cell");
  a_crc_after_last: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (ts_q == T_CRC && fw_ready) |=> ts_q == T_PICK && tcrc_q == CRC_INIT)
    else $error("crc not closed");
  a_rx_word_edge: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    rw_valid |-> redge && !remp_s2_q) else $error("rx word without byte");
  a_tx_cell_len: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    bc_q <= 6'(CELL_BYTES - 1)) else $error("cell length overrun");
  a_hdr_then_pay: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (ts_q == T_HDR && fw_ready) |=> ts_q == T_PAY) else $error("header not followed");
  a_pay_bound: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    tw_q <= 4'(CELL_WORDS)) else $error("burst too long");
endmodule // atm_sar_cell_datapath

// *** verification/phy_framer_model.sv ***
/*
  far-side framer model: sends rx cells on a gated link clock, gathers tx cells.
  assumes clk_in is the core clock of the cell datapath; tx bytes taken at its edges.
*/
`timescale 1ns/1ns
module phy_framer_model
  import sar_cell_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic [7:0] tx_data_in,
  input  wire logic       tx_soc_in,
  input  wire logic       tx_en_in,
  input  wire logic       hold_full_in,
  output logic            tx_full_out,
  output logic            link_clk_out,
  output logic [7:0]      rx_data_out,
  output logic            rx_soc_out,
  output logic            rx_empty_n_out
);
  logic [423:0] cells_q[$];
  logic [423:0] cur = '0;
  int           cnt = 0;
  int           age = 0;
  int           frame_errs = 0;
  int           late_bytes = 0;

  // full raised by the bench well ahead of any real overflow
  assign tx_full_out = hold_full_in;

  // idle link: clock parked low, nothing offered
  initial begin
    link_clk_out = 1'b0;
    rx_data_out = 8'h00;
    rx_soc_out = 1'b0;
    rx_empty_n_out = 1'b1;
  end

  // tx bytes packed into 53-byte cells; bytes long after full are counted
  always @(posedge clk_in) begin
    if (tx_en_in === 1'b1) begin
      if (age >= FULL_LEAD_CYC) late_bytes++;
      if (tx_soc_in !== (cnt == 0)) frame_errs++;
      cur = {cur[415:0], tx_data_in};
      cnt = (tx_soc_in === 1'b1) ? 1 : cnt + 1;
      if (cnt == CELL_BYTES) begin
        cells_q.push_back(cur);
        cnt = 0;
      end
    end
    age = tx_full_out ? age + 1 : 0;
  end

  // one cell, first byte flagged; link clock runs only inside the cell
  task automatic send_cell(input logic [423:0] c);
    for (int i = 0; i < 53; i++) begin
      rx_data_out = c[423-8*i -: 8];
      rx_soc_out = (i == 0);
      rx_empty_n_out = 1'b0;
      #200 link_clk_out = 1'b1;
      #200 link_clk_out = 1'b0;
    end
    // released line must not look like a held byte
    rx_data_out = ~rx_data_out;
    rx_soc_out = 1'b0;
    rx_empty_n_out = 1'b1;
    // one idle link period so back-to-back cells never retouch a pin at once
    #400;
  endtask
endmodule // phy_framer_model

// *** verification/atm_sar_cell_datapath_tb_top.sv ***
/*
  self-checking bench: tx packets in each aal mode, idle fill, phy full,
  rx cells with idle drop and good and bad crc.
  assumes phy_framer_model on the far side and the sar_cell_pkg constants.
*/
`timescale 1ns/1ns
module atm_sar_cell_datapath_tb_top;
  import sar_cell_pkg::*;

  logic        clk_in = 1'b0;
  logic        arst_n_in = 1'b0;
  logic [31:0] host_wdata_in = '0;
  logic        host_wvalid_in = 1'b0;
  logic        host_wlast_in = 1'b0;
  logic [9:0]  host_vc_in = '0;
  logic [1:0]  host_group_in = '0;
  logic [1:0]  aal_mode_in = AAL_5;
  logic [15:0] group_rate_in = '0;
  logic [1:0]  group_sel_in = '0;
  logic        group_load_in = 1'b0;
  logic        hold_full = 1'b0;
  logic        host_wready_out, host_burst_req_out, host_rvalid_out, host_rlast_out;
  logic        host_rcrc_ok_out, host_reom_out, tx_start_of_cell_out, tx_byte_enable_out;
  logic        tx_full_in, rx_link_clk_in, rx_start_of_cell_in, rx_empty_n_in;
  logic [31:0] host_rdata_out;
  logic [9:0]  host_rdma_out;
  logic [7:0]  tx_data_out, rx_data_in;
  logic [31:0] rx_q[$];
  logic        crc_q[$];
  logic        eom_seen[$];
  int          len_q[$];
  int          run = 0;
  int          fails = 0;
  int          checks = 0;

  always #25 clk_in = ~clk_in;

  atm_sar_cell_datapath #(.VC_W(10)) dut (
    .clk_in, .arst_n_in, .host_wdata_in, .host_wvalid_in, .host_wlast_in,
    .host_vc_in, .host_group_in, .aal_mode_in, .group_rate_in, .group_sel_in,
    .group_load_in, .host_wready_out, .host_burst_req_out, .host_rdata_out,
    .host_rvalid_out, .host_rlast_out, .host_rcrc_ok_out, .host_reom_out,
    .host_rdma_out, .tx_data_out, .tx_start_of_cell_out, .tx_byte_enable_out,
    .tx_full_in, .rx_link_clk_in, .rx_data_in, .rx_start_of_cell_in, .rx_empty_n_in
  );

  phy_framer_model partner (
    .clk_in, .tx_data_in(tx_data_out), .tx_soc_in(tx_start_of_cell_out),
    .tx_en_in(tx_byte_enable_out), .hold_full_in(hold_full), .tx_full_out(tx_full_in),
    .link_clk_out(rx_link_clk_in), .rx_data_out(rx_data_in),
    .rx_soc_out(rx_start_of_cell_in), .rx_empty_n_out(rx_empty_n_in)
  );

  // rx words gathered; crc flag and word count taken at each last word
  always @(posedge clk_in) begin
    if (host_rvalid_out === 1'b1) begin
      rx_q.push_back(host_rdata_out);
      run++;
      if (host_rlast_out === 1'b1) begin
        crc_q.push_back(host_rcrc_ok_out);
        eom_seen.push_back(host_reom_out);
        len_q.push_back(run);
        run = 0;
      end
    end
  end

  task automatic tally_and_finish();
    if (fails == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // msb-first crc over whole words, complemented at the end
  function automatic logic [31:0] crc_of(input logic [31:0] w[$]);
    logic [31:0] c;
    c = CRC_INIT;
    foreach (w[i]) for (int b = 31; b >= 0; b--)
      c = {c[30:0], 1'b0} ^ (((c[31] ^ w[i][b]) == 1'b1) ? CRC_POLY : 32'h0);
    return ~c;
  endfunction

  // header with circuit in the channel field and end-of-packet set
  function automatic logic [423:0] mk_cell(input logic [9:0] vc, input logic [31:0] w[$]);
    logic [423:0] c;
    c = {18'h0, vc, 4'b0010, 8'h00, 384'h0};
    for (int i = 0; i < 12; i++) c[383-32*i -: 32] = w[i];
    return c;
  endfunction

  // words held until taken; a stuck handshake ends the run
  task automatic send_pkt(input logic [1:0] mode, input int n, output logic [31:0] w[$]);
    int guard;
    w = {};
    aal_mode_in = mode;
    for (int i = 0; i < n; i++) begin
      w.push_back($urandom);
      host_wdata_in = w[i];
      host_wvalid_in = 1'b1;
      host_wlast_in = (i == n - 1);
      guard = 0;
      do begin
        @(posedge clk_in);
        guard++;
      end while (host_wready_out !== 1'b1 && guard < 3000);
      if (guard >= 3000) begin
        fails++;
        tally_and_finish();
      end
      cmp32(32'(host_burst_req_out), 32'(i == 0), "burst request");
      #1;
    end
    host_wvalid_in = 1'b0;
    host_wlast_in = 1'b0;
  endtask

  // idle cells checked on the way; the first data cell is compared on circuit field, hec slot and payload
  task automatic expect_cell(input logic [31:0] w[$], input bit add_crc);
    logic [423:0] c;
    for (int g = 0; g < 4000; g++) begin
      @(posedge clk_in);
      if (partner.cells_q.size() == 0) continue;
      c = partner.cells_q.pop_front();
      if (c[423:392] === IDLE_HDR) begin
        cmp32(32'(c[383:0] !== {48{IDLE_FILL}}), 32'h0, "idle fill");
        continue;
      end
      // last host slot of an aal5 cell is given over to the crc word
      if (add_crc) begin
        void'(w.pop_back());
        w.push_back(crc_of(w));
      end
      cmp32({22'h0, c[405:396]}, {22'h0, host_vc_in}, "tx circuit");
      cmp32({24'h0, c[391:384]}, 32'h0, "hec slot");
      for (int i = 0; i < 12; i++)
        cmp32(c[383-32*i -: 32], w[i], "tx payload");
      #1 return;
    end
    fails++;
    tally_and_finish();
  endtask

  task automatic wait_cells(input int n);
    for (int g = 0; g < 300 && len_q.size() < n; g++) @(posedge clk_in);
    if (len_q.size() < n) begin
      fails++;
      tally_and_finish();
    end
  endtask

  initial begin
    logic [31:0] w[$];
    logic [31:0] seed;
    seed = $urandom(32'hcf07);
    repeat (6) @(posedge clk_in);
    #1 arst_n_in = 1'b1;
    // group 0 due every cell, the rest never
    for (int g = 0; g < 4; g++) begin
      group_sel_in = 2'(g);
      group_rate_in = (g == 0) ? 16'h0001 : RATE_RESET;
      group_load_in = 1'b1;
      @(posedge clk_in);
      #1;
    end
    group_load_in = 1'b0;
    hold_full = 1'b1;
    repeat (600) @(posedge clk_in);
    #1 hold_full = 1'b0;
    // one packet per mode; aal5 hands its twelfth slot to the crc word
    for (int m = 0; m < 3; m++) begin
      host_vc_in = (m == 0) ? 10'h3ff : 10'($urandom);
      send_pkt(2'(m), 12, w);
      expect_cell(w, m == 0);
    end
    // rx: idle cell dropped, null cell whole, then aal5 good and bad crc
    aal_mode_in = AAL_NULL;
    partner.send_cell({IDLE_HDR, 8'h00, {48{IDLE_FILL}}});
    w = {};
    for (int i = 0; i < 12; i++) w.push_back($urandom);
    partner.send_cell(mk_cell(10'h2a5, w));
    wait_cells(1);
    cmp32(32'(len_q[0]), 32'd12, "rx length");
    for (int i = 0; i < 12; i++) cmp32(rx_q[i], w[i], "rx payload");
    cmp32({22'h0, host_rdma_out}, 32'h2a5, "rx dma");
    #1 aal_mode_in = AAL_5;
    void'(w.pop_back());
    w.push_back(crc_of(w));
    partner.send_cell(mk_cell(10'h155, w));
    w[11] = ~w[11];
    partner.send_cell(mk_cell(10'h155, w));
    wait_cells(3);
    cmp32(32'(crc_q[1]), 32'h1, "crc good");
    cmp32(32'(crc_q[2]), 32'h0, "crc bad");
    cmp32(32'(len_q.size()), 32'd3, "rx cell count");
    // aal3/4 cell whose header marks the end of the message
    #1 aal_mode_in = AAL_34;
    partner.send_cell(mk_cell(10'h0c3, w));
    wait_cells(4);
    cmp32(32'(eom_seen[0]), 32'h0, "eom in null");
    cmp32(32'(eom_seen[3]), 32'h1, "eom in aal34");
    cmp32(32'(crc_q[3]), 32'h1, "aal34 no crc");
    cmp32(32'(partner.frame_errs), 32'h0, "tx framing");
    cmp32(32'(partner.late_bytes), 32'h0, "bytes under full");
    tally_and_finish();
  end
endmodule // atm_sar_cell_datapath_tb_top
